// [verilog/sbes_consts.vh]
// Purpose: Constants for the secondary bus E strobe generator
// Assumes: One clock i_clk (input clock); system clock is half of it
// Notes: Cycle type and phase encodings shared by both design files
`ifndef SBES_CONSTS_VH
`define SBES_CONSTS_VH

// Clock rate of i_clk
`define SBES_CLK_HZ 10000000
// Input clock division ratio to system clock
`define SBES_DIV_RATIO 2

// Bus cycle type codes
`define SBES_CYC_W 3
`define SBES_CYC_IDLE 3'h0
`define SBES_CYC_FETCH 3'h1
`define SBES_CYC_MEM 3'h2
`define SBES_CYC_IORD 3'h3
`define SBES_CYC_IOWR 3'h4
`define SBES_CYC_NMIACK 3'h5
`define SBES_CYC_INTACK 3'h6

// Bus state codes, one per system clock period
`define SBES_TS_W 3
`define SBES_TS_T1 3'h1
`define SBES_TS_T2 3'h2
`define SBES_TS_TW 3'h3
`define SBES_TS_T3 3'h4
`define SBES_TS_OTHER 3'h0

// Half period index within a system clock period
`define SBES_PH_RISE 1'h0
`define SBES_PH_FALL 1'h1

// Free running strobe: system clock periods per high or low phase in low-power modes
`define SBES_FREE_HI_W 2
`define SBES_FREE_HI_SLOW 2'h2
`define SBES_FREE_HI_FAST 2'h1
`define SBES_FREE_LO 2'h1

`endif

// [verilog/sbes_clk_div.v]
// Purpose: Halve the input clock into a system clock phase
// Assumes: Synchronous active low reset
// Notes: o_phase low marks the first half (system clock high)
`timescale 1ns/10ps
`default_nettype none
`include "sbes_consts.vh"

module sbes_clk_div (
  input wire i_clk,
  input wire i_reset_n,
  output wire o_phase,
  output wire o_sys_clk
);

  reg phase_reg;
  wire phase_next;

  assign phase_next = ~phase_reg;

  // Toggle on each rising input edge
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      phase_reg <= `SBES_PH_RISE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign o_phase = phase_reg;
  assign o_sys_clk = ~phase_reg;

endmodule // sbes_clk_div

`default_nettype wire

// [verilog/sbes_e_strobe.v]
// Purpose: E strobe generator for the secondary peripheral bus
// Assumes: Bus state and cycle type inputs change on system clock rising half only
// Notes: One i_clk cycle is half a system clock period
// Functional notes
// - The system clock is the input clock divided by two.
// - Each wait state in fetch, memory or I/O cycles lengthens the strobe high time by one period.
// - An I/O cycle without wait states keeps the strobe low throughout.
// - Fetch and memory cycles hold the strobe high from the T2 rise to the T3 fall.
// - I/O read holds the strobe high from the first wait state rise to the T3 fall.
// - I/O write holds the strobe high from the first wait state rise to the T3 rise.
// - The first cycle of a non-maskable acknowledge is high from T2 rise to T3 fall.
// - The first cycle of a maskable zero acknowledge is high from first wait rise to T3 fall.
// - In bus release, sleep or stop mode the strobe free-runs, high between falling edges for 2 or 1 periods.
`timescale 1ns/10ps
`default_nettype none
`include "sbes_consts.vh"

module sbes_e_strobe (
  input wire i_clk,
  input wire i_reset_n,
  input wire [`SBES_CYC_W-1:0] i_machine_cycle,
  input wire [`SBES_TS_W-1:0] i_bus_state,
  input wire i_first_wait_state_tick,
  input wire i_free_run,
  input wire i_free_run_fast,
  output wire o_sys_clk,
  output wire o_phase,
  output wire o_e_strobe
);

  localparam ST_BUS = 1'b0;
  localparam ST_FREE = 1'b1;

  wire phase;
  reg e_reg;
  reg e_next;
  reg state_reg;
  reg state_next;
  reg [`SBES_FREE_HI_W-1:0] cnt_reg;
  reg [`SBES_FREE_HI_W-1:0] cnt_next;
  reg hi_in_window;
  reg after_wait_reg;
  reg after_wait_next;
  reg free_e_next;
  reg t3_first_half;
  reg hi_mem;
  reg hi_io_rd;
  reg hi_io_wr;

  sbes_clk_div u_div (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .o_phase(phase),
    .o_sys_clk(o_sys_clk)
  );

  // Wait state seen flag, cleared at T1
  always @* begin
    after_wait_next = after_wait_reg;
    if (i_bus_state == `SBES_TS_T1) begin
      after_wait_next = 1'b0;
    end
    if (i_bus_state == `SBES_TS_TW && i_first_wait_state_tick) begin
      after_wait_next = 1'b1;
    end
  end

  // First half of T3
  always @* begin
    t3_first_half = (i_bus_state == `SBES_TS_T3) && (phase == `SBES_PH_RISE);
  end

  // Fetch, memory and non-maskable acknowledge window
  always @* begin
    case (i_bus_state)
      `SBES_TS_T2: begin
        hi_mem = 1'b1;
      end
      `SBES_TS_TW: begin
        hi_mem = 1'b1;
      end
      `SBES_TS_T3: begin
        hi_mem = t3_first_half;
      end
      default: begin
        hi_mem = 1'b0;
      end
    endcase
  end

  // I/O read and maskable acknowledge window
  always @* begin
    case (i_bus_state)
      `SBES_TS_TW: begin
        hi_io_rd = 1'b1;
      end
      `SBES_TS_T3: begin
        hi_io_rd = t3_first_half && after_wait_reg;
      end
      default: begin
        hi_io_rd = 1'b0;
      end
    endcase
  end

  // I/O write window ends at T3 rise
  always @* begin
    case (i_bus_state)
      `SBES_TS_TW: begin
        hi_io_wr = 1'b1;
      end
      default: begin
        hi_io_wr = 1'b0;
      end
    endcase
  end

  // Select by cycle type
  always @* begin
    case (i_machine_cycle)
      `SBES_CYC_FETCH, `SBES_CYC_MEM, `SBES_CYC_NMIACK: begin
        hi_in_window = hi_mem;
      end
      `SBES_CYC_IORD, `SBES_CYC_INTACK: begin
        hi_in_window = hi_io_rd;
      end
      `SBES_CYC_IOWR: begin
        hi_in_window = hi_io_wr;
      end
      default: begin
        hi_in_window = 1'b0;
      end
    endcase
  end

  // Free run toggle, only at system clock falling edges
  always @* begin
    free_e_next = e_reg;
    cnt_next = cnt_reg;
    if (state_reg == ST_BUS) begin
      cnt_next = `SBES_FREE_LO;
    end else if (phase == `SBES_PH_FALL) begin
      if (cnt_reg == `SBES_FREE_HI_FAST) begin
        free_e_next = ~e_reg;
        if (!e_reg) begin
          cnt_next = i_free_run_fast ? `SBES_FREE_HI_FAST : `SBES_FREE_HI_SLOW;
        end else begin
          cnt_next = `SBES_FREE_LO;
        end
      end else begin
        cnt_next = cnt_reg - `SBES_FREE_HI_FAST;
      end
    end
  end

  // Mode select and strobe source
  always @* begin
    state_next = state_reg;
    e_next = 1'b0;
    case (state_reg)
      ST_BUS: begin
        e_next = hi_in_window;
        if (i_free_run && phase == `SBES_PH_FALL) begin
          state_next = ST_FREE;
        end
      end
      ST_FREE: begin
        e_next = free_e_next;
        if (!i_free_run && phase == `SBES_PH_FALL) begin
          state_next = ST_BUS;
          e_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_BUS;
      end
    endcase
  end

  // Strobe for the half cycle that begins at this edge
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      e_reg <= 1'b0;
    end else begin
      e_reg <= e_next;
    end
  end

  // Mode register
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_reg <= ST_BUS;
    end else begin
      state_reg <= state_next;
    end
  end

  // Free run counter
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_reg <= `SBES_FREE_LO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Wait state seen flag
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      after_wait_reg <= 1'b0;
    end else begin
      after_wait_reg <= after_wait_next;
    end
  end

  assign o_phase = phase;
  assign o_e_strobe = e_reg;

endmodule // sbes_e_strobe

`default_nettype wire

// [sim/sbes_e_strobe_asserts.sv]
// Purpose: Strobe timing checks
// Assumes: Bound to sbes_e_strobe
// Notes: Widths in i_clk cycles
`timescale 1ns/10ps
`default_nettype none
module sbes_e_strobe_asserts (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [2:0] i_machine_cycle,
  input wire logic [2:0] i_bus_state,
  input wire logic i_free_run,
  input wire logic i_free_run_fast,
  input wire logic o_phase,
  input wire logic o_sys_clk,
  input wire logic o_e_strobe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_div; $past(i_reset_n, 2) |-> o_phase != $past(o_phase); endproperty
  a_div: assert property (p_div) else $error("phase stuck");
  property p_sys; o_sys_clk == !o_phase; endproperty
  a_sys: assert property (p_sys) else $error("system clock wrong");
  property p_t2; !i_free_run && !o_phase && i_bus_state == 3'h2 && i_machine_cycle inside {3'h1, 3'h2, 3'h5}
    |=> o_e_strobe [*3]; endproperty
  a_t2: assert property (p_t2) else $error("short high");
  property p_fall; !i_free_run && o_phase && i_bus_state == 3'h4 && i_machine_cycle != 3'h4 |=> !o_e_strobe;
  endproperty
  a_fall: assert property (p_fall) else $error("late fall");
  property p_iowr; !i_free_run && i_bus_state == 3'h4 && i_machine_cycle == 3'h4 |=> !o_e_strobe; endproperty
  a_iowr: assert property (p_iowr) else $error("write high");
  property p_io; !i_free_run && i_bus_state inside {3'h1, 3'h2} && i_machine_cycle inside {3'h3, 3'h4, 3'h6}
    |=> !o_e_strobe; endproperty
  a_io: assert property (p_io) else $error("early rise");
  property p_wait; !i_free_run && i_bus_state == 3'h3 && i_machine_cycle != 3'h0 |=> o_e_strobe; endproperty
  a_wait: assert property (p_wait) else $error("wait low");
  property p_idle; !i_free_run [*3] ##0 i_machine_cycle == 3'h0 |=> !o_e_strobe; endproperty
  a_idle: assert property (p_idle) else $error("idle high");
  property p_rst; @(posedge i_clk) disable iff (1'b0) !i_reset_n |=> !o_e_strobe; endproperty
  a_rst: assert property (p_rst) else $error("reset high");
  property p_free; i_free_run && !i_free_run_fast && $rose(o_e_strobe) |-> o_e_strobe [*4] ##1 !o_e_strobe;
  endproperty
  a_free: assert property (p_free) else $error("free width");
  property p_free_fast; i_free_run && i_free_run_fast && $rose(o_e_strobe) |-> o_e_strobe [*2] ##1 !o_e_strobe;
  endproperty
  a_free_fast: assert property (p_free_fast) else $error("fast free width");
endmodule // sbes_e_strobe_asserts
`default_nettype wire

// [sim/sbes_periph.sv]
// Purpose: Slow peripheral on the strobe
// Assumes: Access while strobe high
// Notes: Counts accesses
`timescale 1ns/10ps
`default_nettype none
module sbes_periph (
  input wire logic i_e_strobe,
  output logic [7:0] o_count = 8'h00
);
  always @(posedge i_e_strobe) o_count <= o_count + 8'h01;
endmodule // sbes_periph
`default_nettype wire

// [sim/sbes_e_strobe_bench.sv]
// Purpose: Bench for sbes_e_strobe
// Assumes: 10 MHz clock
// Notes: Widths in i_clk cycles
`timescale 1ns/10ps
`default_nettype none
module sbes_e_strobe_bench;
  logic i_clk = 0, rst_n = 0, fw = 0, fr = 0, frf = 0;
  logic [2:0] mc = 0, bs = 0, t;
  logic [1:0] n;
  logic [7:0] len = 0, np = 0, q[$];
  logic [31:0] lf = 32'hF9A2743A;
  wire ph, e;
  wire [7:0] pc;
  int failures = 0, cmp_count = 0, i;
  always #50 i_clk = ~i_clk;
  sbes_e_strobe uut (.i_clk(i_clk), .i_reset_n(rst_n), .i_machine_cycle(mc), .i_bus_state(bs),
    .i_first_wait_state_tick(fw), .i_free_run(fr), .i_free_run_fast(frf), .o_sys_clk(), .o_phase(ph), .o_e_strobe(e));
  sbes_periph far (.i_e_strobe(e), .o_count(pc));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s exp %0d seen %0d", nm, x, s);
    end
  endtask
  task wrap_up;
    $display("Checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wt(input logic v);
    int k;
    for (k = 0; k < 40 && e !== v; k++) @(negedge i_clk);
    if (e !== v) begin
      failures++;
      wrap_up;
    end
  endtask
  task st(input logic [2:0] m, input logic [2:0] s, input logic f);
    @(posedge i_clk);
    mc <= m;
    bs <= s;
    fw <= f;
    @(posedge i_clk);
  endtask
  task cyc(input logic [2:0] c, input logic [1:0] w);
    int j;
    if (w || c inside {1, 2, 5}) q.push_back(c inside {1, 2, 5} ? 3 + 2 * w : c == 4 ? 2 * w : 1 + 2 * w);
    @(negedge i_clk);
    for (j = 0; j < 4 && ph !== 1; j++) @(negedge i_clk);
    if (ph !== 1) begin
      failures++;
      wrap_up;
    end
    st(c, 1, 0);
    st(c, 2, 0);
    for (j = 0; j < w; j++) st(c, 3, j == 0);
    st(c, 4, 0);
    st(0, 0, 0);
  endtask
  always @(negedge i_clk) begin
    if (e === 1) len++;
    else if (len) begin
      chk("strobe_high_len", len, q.size() ? q.pop_front() : 0);
      np++;
      len = 0;
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    rst_n <= 1;
    for (i = 0; i < 40; i++) begin
      lf = nx(lf);
      t = i < 6 ? i + 1 : lf[2:0] % 6 + 1;
      n = t == 5 ? 0 : lf[4:3] | (t == 6);
      cyc(t, n);
    end
    $display("Bus cycle test done");
    for (i = 0; i < 2; i++) begin
      @(posedge i_clk);
      fr <= 1;
      frf <= i[0];
      repeat (3) begin
        wt(1);
        q.push_back(i ? 2 : 4);
        wt(0);
      end
      @(posedge i_clk);
      fr <= 0;
      repeat (6) @(posedge i_clk);
    end
    $display("Free run test done");
    chk("pending_pulses", q.size(), 0);
    chk("periph_count", pc, np);
    wrap_up;
  end
endmodule // sbes_e_strobe_bench
bind sbes_e_strobe sbes_e_strobe_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_machine_cycle(i_machine_cycle),
  .i_bus_state(i_bus_state), .i_free_run(i_free_run), .i_free_run_fast(i_free_run_fast), .o_phase(o_phase),
  .o_sys_clk(o_sys_clk),
  .o_e_strobe(o_e_strobe));
`default_nettype wire
